// *** src/dsr_pkg.sv ***
// constants for converter source routing and pulse-mode register bank
// assumes byte addresses are four times the register index
package dsr_pkg;
    localparam int DSR_ADDR_W = 12;
    // register indices, byte address is index times four
    localparam logic [9:0] DSR_IDX_DP_ENABLE = 10'h2e0;
    localparam logic [9:0] DSR_IDX_GAIN = 10'h2e2;
    localparam logic [9:0] DSR_IDX_FORMAT = 10'h2e3;
    localparam logic [9:0] DSR_IDX_SOURCE = 10'h2e4;
    localparam logic [9:0] DSR_IDX_PULSE = 10'h2e8;
    localparam logic [9:0] DSR_IDX_INTERP = 10'h2f0;
    // reset values
    localparam logic [7:0] DSR_RST_DP_ENABLE = 8'h00;
    localparam logic [7:0] DSR_RST_GAIN = 8'h00;
    localparam logic [7:0] DSR_RST_FORMAT = 8'h00;
    localparam logic [7:0] DSR_RST_SOURCE = 8'h00;
    localparam logic [7:0] DSR_RST_PULSE = 8'h00;
    localparam logic [7:0] DSR_RST_INTERP = 8'h00;
    // field positions
    localparam int DSR_SRC0_LSB = 0;
    localparam int DSR_SRC1_LSB = 4;
    localparam int DSR_PULSE_A_LSB = 0;
    localparam int DSR_PULSE_B_LSB = 4;
    localparam int DSR_MASK_W = 4;
    localparam int DSR_NUM_UPCONV = 4;
    localparam int DSR_NUM_CONV = 2;
    // writable bits per register, then upconverter enable patterns
    localparam logic [7:0] DSR_WMASK_BIT0 = 8'h01;
    localparam logic [7:0] DSR_WMASK_PULSE = 8'h77;
    localparam logic [3:0] DSR_UPCONV_ALL = 4'hf;
    localparam logic [3:0] DSR_UPCONV_PAIR = 4'h3;

    typedef enum logic [2:0] {
        DSR_PM_NRZ = 3'h0,
        DSR_PM_RTI = 3'h1,
        DSR_PM_RTZ = 3'h2,
        DSR_PM_DRLP = 3'h3,
        DSR_PM_DRHP = 3'h4,
        DSR_PM_RSV5 = 3'h5,
        DSR_PM_OFF = 3'h6,
        DSR_PM_RSV7 = 3'h7
    } dsr_pulse_mode_t;
endpackage

// *** src/dsr_routing_top.sv ***
// register bank and sample routing for two converter channels
// assumes an apb master on pclk; samples arrive synchronous to pclk
`timescale 1ns/1ps
module dsr_routing_top
    import dsr_pkg::*;
#(
    parameter int SAMPLE_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DSR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [SAMPLE_W-1:0] stream_i,
    input wire logic signed [SAMPLE_W-1:0] stream_q,
    input wire logic [DSR_NUM_UPCONV*SAMPLE_W-1:0] upconv_real,
    input wire logic [2*SAMPLE_W-1:0] upconv_imag,
    output logic datapath_run,
    output logic upconv_complex_select,
    output logic [DSR_NUM_UPCONV-1:0] upconv_enable,
    output logic signed [SAMPLE_W-1:0] converter_a_sample,
    output logic signed [SAMPLE_W-1:0] converter_b_sample,
    output logic [2:0] converter_a_pulse_mode,
    output logic [2:0] converter_b_pulse_mode,
    output logic converter_a_enable,
    output logic converter_b_enable
);
    // elaboration-time refusal of widths the accumulator cannot serve
    if (SAMPLE_W < 4 || SAMPLE_W > 28)
    begin : g_bad_width
        $error("dsr_routing_top: SAMPLE_W out of range");
    end

    logic [7:0] dp_enable_r;
    logic [7:0] gain_r;
    logic [7:0] format_r;
    logic [7:0] source_r;
    logic [7:0] pulse_r;
    logic [7:0] interp_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic [9:0] idx;
    logic hit;
    logic [7:0] rd_val;
    logic do_write;

    assign idx = paddr[DSR_ADDR_W-1:2];

    always_comb
    begin
        hit = 1'b1;
        rd_val = 8'h00;
        case (idx)
            DSR_IDX_DP_ENABLE: rd_val = dp_enable_r;
            DSR_IDX_GAIN: rd_val = gain_r;
            DSR_IDX_FORMAT: rd_val = format_r;
            DSR_IDX_SOURCE: rd_val = source_r;
            DSR_IDX_PULSE: rd_val = pulse_r;
            DSR_IDX_INTERP: rd_val = interp_r;
            default: hit = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !hit;
            if (psel && penable && !pready_r && !pwrite)
            begin
                prdata_r <= {24'h00_0000, rd_val};
            end
        end
    end

    assign do_write = psel && penable && pready_r && pwrite && hit;

    // datapath enable; clear holds the datapath in reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dp_enable_r <= DSR_RST_DP_ENABLE;
        end
        else if (do_write && idx == DSR_IDX_DP_ENABLE)
        begin
            dp_enable_r <= pwdata[7:0] & DSR_WMASK_BIT0;
        end
    end

    // two gain bits per upconverter source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_r <= DSR_RST_GAIN;
        end
        else if (do_write && idx == DSR_IDX_GAIN)
        begin
            gain_r <= pwdata[7:0];
        end
    end

    // settings take writes at any time; software keeps them still while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            format_r <= DSR_RST_FORMAT;
        end
        else if (do_write && idx == DSR_IDX_FORMAT)
        begin
            format_r <= pwdata[7:0] & DSR_WMASK_BIT0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            source_r <= DSR_RST_SOURCE;
        end
        else if (do_write && idx == DSR_IDX_SOURCE)
        begin
            source_r <= pwdata[7:0];
        end
    end

    // reserved bits 7 and 3 stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_r <= DSR_RST_PULSE;
        end
        else if (do_write && idx == DSR_IDX_PULSE)
        begin
            pulse_r <= pwdata[7:0] & DSR_WMASK_PULSE;
        end
    end

    // upconverters active or bypassed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interp_r <= DSR_RST_INTERP;
        end
        else if (do_write && idx == DSR_IDX_INTERP)
        begin
            interp_r <= pwdata[7:0] & DSR_WMASK_BIT0;
        end
    end

    logic dp_on;
    logic cplx;
    logic active;
    logic [DSR_MASK_W*SAMPLE_W-1:0] src_vec;
    logic signed [SAMPLE_W-1:0] sum_c [DSR_NUM_CONV];
    logic [DSR_MASK_W-1:0] mask_c [DSR_NUM_CONV];
    logic [2:0] mode_c [DSR_NUM_CONV];
    logic [DSR_NUM_CONV-1:0] conv_on;

    assign dp_on = dp_enable_r[0];
    assign cplx = format_r[0];
    assign active = interp_r[0];
    assign mask_c[0] = source_r[DSR_SRC0_LSB +: DSR_MASK_W];
    assign mask_c[1] = source_r[DSR_SRC1_LSB +: DSR_MASK_W];
    assign mode_c[0] = pulse_r[DSR_PULSE_A_LSB +: 3];
    assign mode_c[1] = pulse_r[DSR_PULSE_B_LSB +: 3];

    // gain code: 0 -> 0 dB, 1 -> -6 dB, 2 and reserved 3 -> -12 dB
    function automatic logic signed [SAMPLE_W-1:0] scale(
        input logic signed [SAMPLE_W-1:0] s,
        input logic [1:0] g
    );
        logic signed [SAMPLE_W-1:0] r;
        r = s;
        case (g)
            2'h0: r = s;
            2'h1: r = s >>> 1;
            default: r = s >>> 2;
        endcase
        return r;
    endfunction

    // candidate source per mask bit
    genvar k;
    generate
        for (k = 0; k < DSR_MASK_W; k++)
        begin : g_src
            logic signed [SAMPLE_W-1:0] pick;
            always_comb
            begin
                pick = '0;
                if (!active)
                begin
                    if (k == 0)
                    begin
                        pick = stream_i;
                    end
                    else if (k == 1)
                    begin
                        pick = stream_q;
                    end
                    else
                    begin
                        pick = '0;
                    end
                end
                else if (cplx && k >= 2)
                begin
                    pick = scale(upconv_imag[(k%2)*SAMPLE_W +: SAMPLE_W], gain_r[2*k +: 2]);
                end
                else
                begin
                    pick = scale(upconv_real[k*SAMPLE_W +: SAMPLE_W], gain_r[2*k +: 2]);
                end
            end
            assign src_vec[k*SAMPLE_W +: SAMPLE_W] = pick;
        end

        for (k = 0; k < DSR_NUM_CONV; k++)
        begin : g_conv
            dsr_sat_sum #(
                .SAMPLE_W(SAMPLE_W)
            ) u_sum (
                .src(src_vec),
                .mask(mask_c[k]),
                .sum(sum_c[k])
            );
            assign conv_on[k] = (mode_c[k] != DSR_PM_RSV5) && (mode_c[k] != DSR_PM_OFF)
                && (mode_c[k] != DSR_PM_RSV7);
        end
    endgenerate

    // converter samples, converter enables and upconverter enables cleared while disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            datapath_run <= 1'b0;
            upconv_complex_select <= 1'b0;
            upconv_enable <= 4'h0;
            converter_a_sample <= '0;
            converter_b_sample <= '0;
            converter_a_pulse_mode <= 3'h0;
            converter_b_pulse_mode <= 3'h0;
            converter_a_enable <= 1'b0;
            converter_b_enable <= 1'b0;
        end
        else
        begin
            datapath_run <= dp_on;
            upconv_complex_select <= cplx;
            if (!dp_on || !active)
            begin
                upconv_enable <= 4'h0;
            end
            else
            begin
                upconv_enable <= cplx ? DSR_UPCONV_PAIR : DSR_UPCONV_ALL;
            end
            converter_a_pulse_mode <= mode_c[0];
            converter_b_pulse_mode <= mode_c[1];
            converter_a_enable <= dp_on && conv_on[0];
            converter_b_enable <= dp_on && conv_on[1];
            converter_a_sample <= (dp_on && conv_on[0]) ? sum_c[0] : '0;
            converter_b_sample <= (dp_on && conv_on[1]) ? sum_c[1] : '0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
endmodule

// *** src/dsr_sat_sum.sv ***
// masked four-input adder with saturation to sample width
// assumes signed two's complement inputs, purely combinational
`timescale 1ns/1ps
module dsr_sat_sum
    import dsr_pkg::*;
#(
    parameter int SAMPLE_W = 16
)
(
    input wire logic [DSR_MASK_W*SAMPLE_W-1:0] src,
    input wire logic [DSR_MASK_W-1:0] mask,
    output logic signed [SAMPLE_W-1:0] sum
);
    localparam int ACC_W = SAMPLE_W + 2;
    localparam logic signed [ACC_W-1:0] MAX_V = ACC_W'((1 << (SAMPLE_W - 1)) - 1);
    localparam logic signed [ACC_W-1:0] MIN_V = -MAX_V - ACC_W'(1);

    logic signed [ACC_W-1:0] acc;

    always_comb
    begin
        acc = '0;
        for (int k = 0; k < DSR_MASK_W; k++)
        begin
            if (mask[k])
            begin
                acc = acc + ACC_W'(signed'(src[k*SAMPLE_W +: SAMPLE_W]));
            end
        end
        if (acc > MAX_V)
        begin
            sum = MAX_V[SAMPLE_W-1:0];
        end
        else if (acc < MIN_V)
        begin
            sum = MIN_V[SAMPLE_W-1:0];
        end
        else
        begin
            sum = acc[SAMPLE_W-1:0];
        end
    end
endmodule

// *** verif/dsr_monitor.sv ***
// port checker for the routing register bank
// assumes it is bound onto dsr_routing_top
`timescale 1ns/1ps
module dsr_monitor
    import dsr_pkg::*;
#(
    parameter int SAMPLE_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic datapath_run,
    input wire logic upconv_complex_select,
    input wire logic [DSR_NUM_UPCONV-1:0] upconv_enable,
    input wire logic signed [SAMPLE_W-1:0] converter_a_sample,
    input wire logic [2:0] converter_a_pulse_mode,
    input wire logic [2:0] converter_b_pulse_mode,
    input wire logic converter_a_enable,
    input wire logic converter_b_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    a_one_wait: assert property (setup_s |=> answer_s) else $error("no single wait state");
    a_err_ready: assert property (pslverr |-> pready && psel && penable) else $error("lone error");
    a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_run_gates: assert property (converter_a_enable |-> datapath_run)
        else $error("enable without run");
    a_off_zero: assert property (!datapath_run [*2] |-> converter_a_sample == 0)
        else $error("sample while held");
    a_mode_off_a: assert property (converter_a_pulse_mode >= 3'h5 |-> !converter_a_enable)
        else $error("a enabled in off mode");
    a_mode_off_b: assert property (converter_b_pulse_mode >= 3'h5 |-> !converter_b_enable)
        else $error("b enabled in off mode");
    a_cplx_pair: assert property (upconv_complex_select |-> (upconv_enable & 4'hc) == 4'h0)
        else $error("complex enables upper pair");
    a_real_all: assert property (!upconv_complex_select |-> upconv_enable inside {4'h0, 4'hf})
        else $error("real enable pattern");
    a_mode_write: assert property (!$stable(converter_b_pulse_mode) |-> $past(pready && pwrite, 2))
        else $error("mode moved without write");
endmodule

bind dsr_routing_top dsr_monitor #(.SAMPLE_W(SAMPLE_W)) mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .datapath_run(datapath_run), .upconv_complex_select(upconv_complex_select),
    .upconv_enable(upconv_enable), .converter_a_sample(converter_a_sample),
    .converter_a_pulse_mode(converter_a_pulse_mode), .converter_b_pulse_mode(converter_b_pulse_mode),
    .converter_a_enable(converter_a_enable), .converter_b_enable(converter_b_enable));

// *** verif/dsr_routing_top_tb_top.sv ***
// self-checking bench for the routing register bank
// assumes dsr_monitor is bound onto the design
`timescale 1ns/1ps
module dsr_routing_top_tb_top;
    import dsr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, run, cx, ea, eb, err;
    logic signed [15:0] si = 0, sq = 0, oa, ob;
    logic [63:0] ur = 0;
    logic [31:0] ui = 0;
    logic [3:0] ue;
    logic [2:0] ma, mb;
    int num_errors = 0, compares = 0;
    initial forever #12.5 pclk = ~pclk;
    dsr_routing_top #(.SAMPLE_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stream_i(si), .stream_q(sq), .upconv_real(ur),
        .upconv_imag(ui), .datapath_run(run), .upconv_complex_select(cx), .upconv_enable(ue),
        .converter_a_sample(oa), .converter_b_sample(ob), .converter_a_pulse_mode(ma),
        .converter_b_pulse_mode(mb), .converter_a_enable(ea), .converter_b_enable(eb));
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string n, input logic [9:0] i, input logic [7:0] e);
        apb(0, i, 0);
        chk(n, e, rd);
    endtask
    task automatic cfg(input logic [7:0] f, a, s, p, g);
        apb(1, DSR_IDX_DP_ENABLE, 0);
        apb(1, DSR_IDX_FORMAT, f);
        apb(1, DSR_IDX_INTERP, a);
        apb(1, DSR_IDX_SOURCE, s);
        apb(1, DSR_IDX_PULSE, p);
        apb(1, DSR_IDX_GAIN, g);
        apb(1, DSR_IDX_DP_ENABLE, 1);
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [3:0] pick(input logic a, c);
        logic [3:0] m;
        m = 4'($urandom);
        if (!a)
            m = m[0] ? 4'h1 : 4'h2;
        else if (c)
            m = m[3] ? {2'b0, m[2:1]} : {m[2:1], 2'b0};
        return m;
    endfunction
    function automatic logic signed [15:0] ex(input logic [3:0] m, input logic a, c,
        input logic [7:0] g);
        int s, v, sh;
        s = 0;
        for (int k = 0; k < 4; k++)
        begin
            if (a)
                v = (c && k > 1) ? $signed(ui[(k%2)*16 +: 16]) : $signed(ur[k*16 +: 16]);
            else
                v = k == 0 ? si : k == 1 ? sq : 0;
            sh = !a ? 0 : g[2*k +: 2] == 2'h3 ? 2 : g[2*k +: 2];
            if (m[k])
                s += v >>> sh;
        end
        if (s > 32767)
            s = 32767;
        if (s < -32768)
            s = -32768;
        return 16'(s);
    endfunction
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test;
    end
    initial
    begin
        logic [7:0] s, p, g;
        logic f, a;
        s = 8'($urandom(32'hb8b7b3d9));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdc("fmt", DSR_IDX_FORMAT, 0);
        rdc("src", DSR_IDX_SOURCE, 0);
        rdc("pulse", DSR_IDX_PULSE, 0);
        apb(1, DSR_IDX_SOURCE, 8'ha5);
        apb(1, 10'h3ff, 8'hff);
        chk("werr", 1, err);
        rdc("src", DSR_IDX_SOURCE, 8'ha5);
        chk("okerr", 0, err);
        rdc("miss", 10'h3ff, 0);
        chk("rerr", 1, err);
        apb(1, DSR_IDX_PULSE, 8'hff);
        rdc("pulse", DSR_IDX_PULSE, 8'h77);
        apb(1, DSR_IDX_FORMAT, 8'hff);
        rdc("fmt", DSR_IDX_FORMAT, 1);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            cfg(0, 0, 0, {1'b0, 3'(7 - k), 1'b0, 3'(k)}, 0);
            chk("mode_a", k, ma);
            chk("mode_b", 7 - k, mb);
            chk("en_a", k < 5, ea);
            chk("en_b", k > 2, eb);
        end
        $display("test pulse modes done");
        for (int n = 0; n < 40; n++)
        begin
            f = n == 0 ? 1'b0 : 1'($urandom);
            a = n == 0 ? 1'b1 : 1'($urandom);
            g = n == 0 ? 8'h00 : 8'($urandom);
            p = n % 5 == 4 ? 8'h66 : 8'h00;
            s = {pick(a, f), n == 0 ? 4'hf : pick(a, f)};
            cfg({7'h0, f}, {7'h0, a}, s, p, g);
            si <= 16'($signed(14'($urandom)));
            sq <= 16'($signed(14'($urandom)));
            ui <= {16'($signed(14'($urandom))), 16'($signed(14'($urandom)))};
            for (int k = 0; k < 4; k++)
                ur[k*16 +: 16] <= n == 0 ? 16'h7fff : 16'($signed(14'($urandom)));
            repeat (2) @(posedge pclk);
            #1;
            chk("cx", f, cx);
            chk("ue", a ? (f ? 4'h3 : 4'hf) : 4'h0, ue);
            chk("oa", p != 0 ? 16'sh0 : ex(s[3:0], a, f, g), oa);
            chk("ob", p != 0 ? 16'sh0 : ex(s[7:4], a, f, g), ob);
            @(posedge pclk);
        end
        $display("test routing done");
        apb(1, DSR_IDX_DP_ENABLE, 0);
        repeat (2) @(posedge pclk);
        #1;
        chk("run", 0, run);
        chk("oa", 0, oa);
        chk("ue", 0, ue);
        $display("test hold done");
        stop_test;
    end
endmodule
